/* hw/iso_out_pkg.sv */
// Shared constants for the isochronous transmit engine: register offsets,
// field positions, reset values, descriptor layout and engine states.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package iso_out_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TX_EVENT = 8'h00;
  localparam logic [7:0] OFS_TX_MASK = 8'h04;
  localparam logic [7:0] OFS_GLOBAL = 8'h08;
  localparam logic [7:0] OFS_GLOBAL_MASK = 8'h0c;
  localparam logic [7:0] OFS_CTX_SEL = 8'h10;
  localparam logic [7:0] OFS_CTX_CTRL = 8'h14;
  localparam logic [7:0] OFS_CTX_PTR = 8'h18;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_CM_BIT = 31;
  localparam int CTRL_RUN_BIT = 15;
  localparam int CTRL_WAKE_BIT = 12;
  localparam int CTRL_ACTIVE_BIT = 10;
  localparam int GLB_TX_BIT = 0;
  localparam int GLB_MISMATCH_BIT = 1;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [1:0] GMASK_RST = 2'h0;

  // ----------------------------------------------------------------
  // Descriptor block: six quadlets read in order
  // ----------------------------------------------------------------
  localparam logic [2:0] DQ_CTRL = 3'h0;
  localparam logic [2:0] DQ_SKIP = 3'h1;
  localparam logic [2:0] DQ_HDR0 = 3'h2;
  localparam logic [2:0] DQ_HDR1 = 3'h3;
  localparam logic [2:0] DQ_DATA = 3'h4;
  localparam logic [2:0] DQ_BRANCH = 3'h5;
  localparam int DCTRL_IRQ_BIT = 0;

  // Internal header fields
  localparam int H0_SY_LSB = 0;
  localparam int H0_TCODE_LSB = 4;
  localparam int H0_CHAN_LSB = 8;
  localparam int H0_TAG_LSB = 14;
  localparam int H0_SPD_LSB = 16;
  localparam int H1_LEN_LSB = 16;

  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SCAN = 3'h1,
    ST_FETCH = 3'h2,
    ST_HDR = 3'h3,
    ST_PAYLOAD = 3'h4,
    ST_FINISH = 3'h5
  } eng_state_t;

endpackage : iso_out_pkg

/* hw/tx_quad_packer.sv */
// Payload packer: turns byte-aligned host quadlets into wire quadlets.
// Assumes one host word is offered only while need_word_out is high.
`timescale 1ns/1ns
`default_nettype none

module tx_quad_packer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Job
  input wire logic start_in,
  input wire logic [1:0] offset_in,
  input wire logic [15:0] len_in,
  // Host words, byte 0 in bits 7:0
  input wire logic word_valid_in,
  input wire logic [31:0] word_in,
  output logic need_word_out,
  // Wire quadlets, byte 0 in bits 31:24
  output logic out_valid_out,
  output logic out_last_out,
  output logic [31:0] out_data_out,
  output logic done_out
);

  typedef struct packed {
    logic busy;
    logic have;
    logic [1:0] bidx;
    logic [1:0] ocnt;
    logic [15:0] rem;
    logic [31:0] word;
    logic [31:0] acc;
    logic ov;
    logic ol;
    logic [31:0] od;
    logic done;
  } pk_state_t;

  pk_state_t s_r;
  pk_state_t s_nxt;
  logic [31:0] acc_new;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ov = 1'b0;
    s_nxt.ol = 1'b0;
    s_nxt.done = 1'b0;
    acc_new = s_r.acc | ({24'h00_0000, s_r.word[{s_r.bidx, 3'b000} +: 8]} << {~s_r.ocnt, 3'b000});
    if (start_in)
    begin
      // Odd start address is just a first byte index
      s_nxt.busy = (len_in != 16'h0000);
      s_nxt.rem = len_in;
      s_nxt.bidx = offset_in;
      s_nxt.have = 1'b0;
      s_nxt.ocnt = 2'h0;
      s_nxt.acc = 32'h0000_0000;
      s_nxt.done = (len_in == 16'h0000);
    end
    else if (s_r.busy && !s_r.have)
    begin
      if (word_valid_in)
      begin
        s_nxt.word = word_in;
        s_nxt.have = 1'b1;
      end
    end
    else if (s_r.busy)
    begin
      s_nxt.rem = s_r.rem - 16'h0001;
      s_nxt.bidx = s_r.bidx + 2'h1;
      if (s_r.bidx == 2'h3)
        s_nxt.have = 1'b0;
      if (s_r.ocnt == 2'h3 || s_r.rem == 16'h0001)
      begin
        // Unfilled lanes of acc are still zero: that is the padding
        s_nxt.ov = 1'b1;
        s_nxt.od = acc_new;
        s_nxt.acc = 32'h0000_0000;
        s_nxt.ocnt = 2'h0;
        if (s_r.rem == 16'h0001)
        begin
          s_nxt.ol = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.have = 1'b0;
          s_nxt.done = 1'b1;
        end
      end
      else
      begin
        s_nxt.acc = acc_new;
        s_nxt.ocnt = s_r.ocnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign need_word_out = s_r.busy & ~s_r.have;
  assign out_valid_out = s_r.ov;
  assign out_last_out = s_r.ol;
  assign out_data_out = s_r.od;
  assign done_out = s_r.done;

endmodule : tx_quad_packer

`default_nettype wire

/* hw/iso_out_engine.sv */
// Isochronous transmit engine: context scan per bus cycle, descriptor
// fetch, packet build, resume on wake, per-context events and summary.
// Assumes a host memory read port with one quadlet per request and a
// link that takes one quadlet per cycle while TX_VALID_OUT is high.
//
// Functional notes
// - Wake after end re-reads ending descriptor
// - One event bit per context, up to 32
// - Per-context mask bit enables its interrupt
// - Shared summary bit on any context event
// - After mismatch, start-on-cycle contexts stay inactive
// - Bus reset leaves transmit untouched
// - Packet is one header quadlet plus payload
// - Payload may start at any byte address
// - Three-bit speed selects transmit speed
// - Tag, channel, tcode, sy go into header
// - Sixteen-bit length sets payload byte count
// - First payload byte lands in byte 0
// - Zero bytes pad to whole quadlets
// - Wire header rebuilt without the speed field
// - Per cycle load and branch, or skip
`timescale 1ns/1ns
`default_nettype none

module iso_out_engine #(
  parameter int N_CTX = 32
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // Bus cycle events from the link
  input wire logic CYCLE_TICK_IN,
  input wire logic CYCLE_LOST_IN,
  input wire logic CYCLE_MISMATCH_IN,
  // Host memory reads
  output logic MEM_RD_OUT,
  output logic [31:0] MEM_ADDR_OUT,
  input wire logic MEM_VALID_IN,
  input wire logic [31:0] MEM_DATA_IN,
  // Packet stream to the link
  output logic TX_VALID_OUT,
  output logic TX_FIRST_OUT,
  output logic TX_LAST_OUT,
  output logic [31:0] TX_DATA_OUT,
  output logic [2:0] TX_SPEED_OUT,
  // Interrupt
  output logic IRQ_OUT
);

  localparam int CW = (N_CTX > 1) ? $clog2(N_CTX) : 1;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    iso_out_pkg::eng_state_t st;
    logic wait_r;
    logic [31:0] rdata;
    logic [N_CTX-1:0] tx_ctx_event_bits;
    logic [N_CTX-1:0] tx_ctx_enable_bits;
    logic [1:0] global_event_reg;
    logic [1:0] gmask;
    logic [CW-1:0] sel;
    logic [N_CTX-1:0] run;
    logic [N_CTX-1:0] wake;
    logic [N_CTX-1:0] active;
    logic [N_CTX-1:0] start_on_cycle_en;
    logic [N_CTX-1:0] ended_skip;
    logic [N_CTX-1:0][31:0] ptr;
    logic [CW-1:0] cur;
    logic lost;
    logic waking;
    logic [2:0] qidx;
    logic [5:0][31:0] desc;
    logic mem_rd;
    logic [31:0] mem_addr;
    logic pk_start;
    logic tx_valid;
    logic tx_first;
    logic tx_last;
    logic [31:0] tx_data;
    logic [2:0] tx_spd;
    logic irq;
  } eng_t;

  eng_t s_r;
  eng_t s_nxt;

  logic pk_need;
  logic pk_ovalid;
  logic pk_olast;
  logic [31:0] pk_odata;
  logic pk_done;
  logic pk_word_valid;

  // ----------------------------------------------------------------
  // Payload packer
  // ----------------------------------------------------------------
  assign pk_word_valid = MEM_VALID_IN & s_r.mem_rd & (s_r.st == iso_out_pkg::ST_PAYLOAD);

  tx_quad_packer u_packer (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .start_in(s_r.pk_start),
    .offset_in(s_r.desc[iso_out_pkg::DQ_DATA][1:0]),
    .len_in(s_r.desc[iso_out_pkg::DQ_HDR1][iso_out_pkg::H1_LEN_LSB +: 16]),
    .word_valid_in(pk_word_valid),
    .word_in(MEM_DATA_IN),
    .need_word_out(pk_need),
    .out_valid_out(pk_ovalid),
    .out_last_out(pk_olast),
    .out_data_out(pk_odata),
    .done_out(pk_done)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic req;
    logic take;
    logic [31:0] bm;
    logic [31:0] rd;
    logic [31:0] nxt_ptr;
    logic [31:0] hdr0;
    logic [31:0] hdr1;
    logic hit;
    logic [CW-1:0] wake_idx;
    logic eligible;
    logic sel_ok;
    req = AVS_READ_IN | AVS_WRITE_IN;
    take = req & ~s_r.wait_r;
    bm = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
          {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
    rd = 32'h0000_0000;
    nxt_ptr = 32'h0000_0000;
    hdr0 = s_r.desc[iso_out_pkg::DQ_HDR0];
    hdr1 = s_r.desc[iso_out_pkg::DQ_HDR1];
    hit = 1'b0;
    wake_idx = '0;
    sel_ok = (int'(s_r.sel) < N_CTX);
    eligible = s_r.run[s_r.cur] & s_r.active[s_r.cur]
               & ~(s_r.global_event_reg[iso_out_pkg::GLB_MISMATCH_BIT]
                   & s_r.start_on_cycle_en[s_r.cur]);

    s_nxt = s_r;
    s_nxt.pk_start = 1'b0;
    s_nxt.tx_valid = 1'b0;
    s_nxt.tx_first = 1'b0;
    s_nxt.tx_last = 1'b0;

    // --------------------------------------------------------------
    // Register access: one wait cycle, data ready at the taking edge
    // --------------------------------------------------------------
    s_nxt.wait_r = ~(req & s_r.wait_r);
    unique case (AVS_ADDRESS_IN)
      iso_out_pkg::OFS_TX_EVENT: rd[N_CTX-1:0] = s_r.tx_ctx_event_bits;
      iso_out_pkg::OFS_TX_MASK: rd[N_CTX-1:0] = s_r.tx_ctx_enable_bits;
      iso_out_pkg::OFS_GLOBAL: rd[1:0] = s_r.global_event_reg;
      iso_out_pkg::OFS_GLOBAL_MASK: rd[1:0] = s_r.gmask;
      iso_out_pkg::OFS_CTX_SEL: rd[CW-1:0] = s_r.sel;
      iso_out_pkg::OFS_CTX_CTRL:
      begin
        rd[iso_out_pkg::CTRL_CM_BIT] = sel_ok & s_r.start_on_cycle_en[s_r.sel];
        rd[iso_out_pkg::CTRL_RUN_BIT] = sel_ok & s_r.run[s_r.sel];
        rd[iso_out_pkg::CTRL_WAKE_BIT] = sel_ok & s_r.wake[s_r.sel];
        rd[iso_out_pkg::CTRL_ACTIVE_BIT] = sel_ok & s_r.active[s_r.sel];
      end
      iso_out_pkg::OFS_CTX_PTR: rd = sel_ok ? s_r.ptr[s_r.sel] : 32'h0000_0000;
      default: rd = 32'h0000_0000;
    endcase
    if (req && s_r.wait_r)
      s_nxt.rdata = rd;

    // Only the bits actually returned are cleared, so late events survive
    if (take && AVS_READ_IN)
    begin
      if (AVS_ADDRESS_IN == iso_out_pkg::OFS_TX_EVENT)
        s_nxt.tx_ctx_event_bits = s_r.tx_ctx_event_bits & ~s_r.rdata[N_CTX-1:0];
      if (AVS_ADDRESS_IN == iso_out_pkg::OFS_GLOBAL)
        s_nxt.global_event_reg[iso_out_pkg::GLB_TX_BIT] =
          s_r.global_event_reg[iso_out_pkg::GLB_TX_BIT]
          & ~s_r.rdata[iso_out_pkg::GLB_TX_BIT];
    end

    if (take && AVS_WRITE_IN)
    begin
      unique case (AVS_ADDRESS_IN)
        iso_out_pkg::OFS_TX_MASK:
          s_nxt.tx_ctx_enable_bits = (s_r.tx_ctx_enable_bits & ~bm[N_CTX-1:0])
                                     | (AVS_WRITEDATA_IN[N_CTX-1:0] & bm[N_CTX-1:0]);
        iso_out_pkg::OFS_GLOBAL:
          // Mismatch bit is write-one-to-clear, never cleared by a read
          s_nxt.global_event_reg[iso_out_pkg::GLB_MISMATCH_BIT] =
            s_r.global_event_reg[iso_out_pkg::GLB_MISMATCH_BIT]
            & ~(AVS_WRITEDATA_IN[iso_out_pkg::GLB_MISMATCH_BIT] & AVS_BYTEENABLE_IN[0]);
        iso_out_pkg::OFS_GLOBAL_MASK:
          if (AVS_BYTEENABLE_IN[0])
            s_nxt.gmask = AVS_WRITEDATA_IN[1:0];
        iso_out_pkg::OFS_CTX_SEL:
          if (AVS_BYTEENABLE_IN[0])
            s_nxt.sel = AVS_WRITEDATA_IN[CW-1:0];
        iso_out_pkg::OFS_CTX_CTRL:
          if (sel_ok)
          begin
            if (AVS_BYTEENABLE_IN[3])
              s_nxt.start_on_cycle_en[s_r.sel] = AVS_WRITEDATA_IN[iso_out_pkg::CTRL_CM_BIT];
            if (AVS_BYTEENABLE_IN[1])
            begin
              s_nxt.run[s_r.sel] = AVS_WRITEDATA_IN[iso_out_pkg::CTRL_RUN_BIT];
              s_nxt.wake[s_r.sel] = s_r.wake[s_r.sel]
                                    | AVS_WRITEDATA_IN[iso_out_pkg::CTRL_WAKE_BIT];
              if (AVS_WRITEDATA_IN[iso_out_pkg::CTRL_RUN_BIT] && !s_r.run[s_r.sel]
                  && s_r.ptr[s_r.sel][3:0] != 4'h0
                  && !(s_nxt.start_on_cycle_en[s_r.sel]
                    && s_r.global_event_reg[iso_out_pkg::GLB_MISMATCH_BIT]))
              begin
                s_nxt.active[s_r.sel] = 1'b1;
                s_nxt.ended_skip[s_r.sel] = 1'b0;
              end
              // A context in flight drops active only when its block ends
              if (!AVS_WRITEDATA_IN[iso_out_pkg::CTRL_RUN_BIT]
                  && !(s_r.st != iso_out_pkg::ST_IDLE && s_r.cur == s_r.sel))
              begin
                s_nxt.active[s_r.sel] = 1'b0;
                s_nxt.wake[s_r.sel] = 1'b0;
              end
            end
          end
        iso_out_pkg::OFS_CTX_PTR:
          if (sel_ok && !s_r.active[s_r.sel])
            s_nxt.ptr[s_r.sel] = (s_r.ptr[s_r.sel] & ~bm) | (AVS_WRITEDATA_IN & bm);
        default:
        begin
        end
      endcase
    end

    // Hardware set wins over a software clear in the same cycle
    if (CYCLE_MISMATCH_IN)
      s_nxt.global_event_reg[iso_out_pkg::GLB_MISMATCH_BIT] = 1'b1;

    // Lowest stopped context with a pending wake
    for (int i = N_CTX - 1; i >= 0; i--)
    begin
      if (s_r.wake[i] && s_r.run[i] && !s_r.active[i])
      begin
        hit = 1'b1;
        wake_idx = CW'(i);
      end
    end

    // --------------------------------------------------------------
    // Engine; no bus reset input, so transmit never sees one
    // --------------------------------------------------------------
    unique case (s_r.st)
      iso_out_pkg::ST_IDLE:
        if (CYCLE_TICK_IN)
        begin
          s_nxt.cur = '0;
          s_nxt.lost = CYCLE_LOST_IN;
          s_nxt.st = iso_out_pkg::ST_SCAN;
        end
        else if (hit)
        begin
          s_nxt.cur = wake_idx;
          s_nxt.waking = 1'b1;
          s_nxt.qidx = 3'h0;
          s_nxt.st = iso_out_pkg::ST_FETCH;
        end
      iso_out_pkg::ST_SCAN:
        if (eligible)
        begin
          s_nxt.qidx = 3'h0;
          s_nxt.waking = 1'b0;
          s_nxt.st = iso_out_pkg::ST_FETCH;
        end
        else if (int'(s_r.cur) == N_CTX - 1)
          s_nxt.st = iso_out_pkg::ST_IDLE;
        else
          s_nxt.cur = s_r.cur + 1'b1;
      iso_out_pkg::ST_FETCH:
        if (!s_r.mem_rd)
        begin
          s_nxt.mem_rd = 1'b1;
          s_nxt.mem_addr = {s_r.ptr[s_r.cur][31:4], 4'h0} + {27'h000_0000, s_r.qidx, 2'b00};
        end
        else if (MEM_VALID_IN)
        begin
          s_nxt.mem_rd = 1'b0;
          s_nxt.desc[s_r.qidx] = MEM_DATA_IN;
          s_nxt.qidx = s_r.qidx + 3'h1;
          if (s_r.qidx == iso_out_pkg::DQ_BRANCH && s_r.waking)
          begin
            // Re-read descriptor: take whichever pointer ended the list
            nxt_ptr = s_r.ended_skip[s_r.cur] ? s_r.desc[iso_out_pkg::DQ_SKIP] : MEM_DATA_IN;
            s_nxt.wake[s_r.cur] = 1'b0;
            s_nxt.waking = 1'b0;
            if (nxt_ptr[3:0] != 4'h0 && !(s_r.start_on_cycle_en[s_r.cur]
                && s_r.global_event_reg[iso_out_pkg::GLB_MISMATCH_BIT]))
            begin
              s_nxt.ptr[s_r.cur] = nxt_ptr;
              s_nxt.active[s_r.cur] = s_r.run[s_r.cur];
            end
            s_nxt.st = iso_out_pkg::ST_IDLE;
          end
          else if (s_r.qidx == iso_out_pkg::DQ_BRANCH)
            s_nxt.st = s_r.lost ? iso_out_pkg::ST_FINISH : iso_out_pkg::ST_HDR;
        end
      iso_out_pkg::ST_HDR:
      begin
        s_nxt.tx_valid = 1'b1;
        s_nxt.tx_first = 1'b1;
        s_nxt.tx_last = (hdr1[iso_out_pkg::H1_LEN_LSB +: 16] == 16'h0000);
        s_nxt.tx_data = {hdr1[iso_out_pkg::H1_LEN_LSB +: 16],
                         hdr0[iso_out_pkg::H0_TAG_LSB +: 2],
                         hdr0[iso_out_pkg::H0_CHAN_LSB +: 6],
                         hdr0[iso_out_pkg::H0_TCODE_LSB +: 4],
                         hdr0[iso_out_pkg::H0_SY_LSB +: 4]};
        s_nxt.tx_spd = hdr0[iso_out_pkg::H0_SPD_LSB +: 3];
        s_nxt.pk_start = 1'b1;
        s_nxt.mem_addr = {s_r.desc[iso_out_pkg::DQ_DATA][31:2], 2'b00};
        s_nxt.st = iso_out_pkg::ST_PAYLOAD;
      end
      iso_out_pkg::ST_PAYLOAD:
      begin
        s_nxt.tx_valid = pk_ovalid;
        s_nxt.tx_last = pk_olast;
        s_nxt.tx_data = pk_odata;
        if (!s_r.mem_rd && pk_need && !s_r.pk_start)
          s_nxt.mem_rd = 1'b1;
        else if (s_r.mem_rd && MEM_VALID_IN)
        begin
          s_nxt.mem_rd = 1'b0;
          s_nxt.mem_addr = s_r.mem_addr + 32'h0000_0004;
        end
        if (pk_done)
          s_nxt.st = iso_out_pkg::ST_FINISH;
      end
      iso_out_pkg::ST_FINISH:
      begin
        nxt_ptr = s_r.lost ? s_r.desc[iso_out_pkg::DQ_SKIP]
                           : s_r.desc[iso_out_pkg::DQ_BRANCH];
        if (!s_r.lost && s_r.desc[iso_out_pkg::DQ_CTRL][iso_out_pkg::DCTRL_IRQ_BIT])
        begin
          s_nxt.tx_ctx_event_bits[s_r.cur] = 1'b1;
          s_nxt.global_event_reg[iso_out_pkg::GLB_TX_BIT] = 1'b1;
        end
        if (nxt_ptr[3:0] == 4'h0)
        begin
          // Keep the ending descriptor's address for a later wake
          s_nxt.active[s_r.cur] = 1'b0;
          s_nxt.ended_skip[s_r.cur] = s_r.lost;
        end
        else
        begin
          s_nxt.ptr[s_r.cur] = nxt_ptr;
          if (!s_r.run[s_r.cur])
            s_nxt.active[s_r.cur] = 1'b0;
        end
        if (int'(s_r.cur) == N_CTX - 1)
          s_nxt.st = iso_out_pkg::ST_IDLE;
        else
        begin
          s_nxt.cur = s_r.cur + 1'b1;
          s_nxt.st = iso_out_pkg::ST_SCAN;
        end
      end
      default: s_nxt.st = iso_out_pkg::ST_IDLE;
    endcase

    // --------------------------------------------------------------
    // Interrupt level
    // --------------------------------------------------------------
    s_nxt.irq = (s_nxt.global_event_reg[iso_out_pkg::GLB_TX_BIT]
                 & s_nxt.gmask[iso_out_pkg::GLB_TX_BIT]
                 & |(s_nxt.tx_ctx_event_bits & s_nxt.tx_ctx_enable_bits))
                | (s_nxt.global_event_reg[iso_out_pkg::GLB_MISMATCH_BIT]
                   & s_nxt.gmask[iso_out_pkg::GLB_MISMATCH_BIT]);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      s_r <= '0;
      s_r.st <= iso_out_pkg::ST_IDLE;
      s_r.wait_r <= 1'b1;
      s_r.tx_ctx_enable_bits <= iso_out_pkg::MASK_RST[N_CTX-1:0];
      s_r.gmask <= iso_out_pkg::GMASK_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign AVS_READDATA_OUT = s_r.rdata;
  assign AVS_WAITREQUEST_OUT = s_r.wait_r;
  assign MEM_RD_OUT = s_r.mem_rd;
  assign MEM_ADDR_OUT = s_r.mem_addr;
  assign TX_VALID_OUT = s_r.tx_valid;
  assign TX_FIRST_OUT = s_r.tx_first;
  assign TX_LAST_OUT = s_r.tx_last;
  assign TX_DATA_OUT = s_r.tx_data;
  assign TX_SPEED_OUT = s_r.tx_spd;
  assign IRQ_OUT = s_r.irq;

endmodule : iso_out_engine

`default_nettype wire

/* sim/host_mem_model.sv */
// Host memory partner: one quadlet per read, answering promptly and slowly in turn.
// Assumes the bench preloads mem and the engine holds rd until valid.
`timescale 1ns/1ns
`default_nettype none
module host_mem_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic rd_in,
  input wire logic [31:0] addr_in,
  output logic valid_out,
  output logic [31:0] data_out
);
  logic [31:0] mem [0:255];
  int cnt;
  logic slow;
  // Idle data keeps toggling so a stale quadlet never looks valid
  always @(posedge clk_in)
  begin
    valid_out <= 1'b0;
    data_out <= ~data_out;
    if (rst_in)
    begin
      cnt <= 0;
      slow <= 1'b0;
    end
    else if (rd_in && !valid_out)
    begin
      cnt <= cnt + 1;
      if (cnt >= (slow ? 3 : 0))
      begin
        valid_out <= 1'b1;
        data_out <= mem[addr_in[9:2]];
        cnt <= 0;
        slow <= ~slow;
      end
    end
  end
endmodule : host_mem_model
`default_nettype wire

/* sim/iso_out_properties.sv */
// Timing checks on the engine's ports.
// Bound into every engine instance below.
`timescale 1ns/1ns
`default_nettype none
module iso_out_checker #(
  parameter int N_CTX = 32
) (
  // Clock, reset, bus
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic AVS_WAITREQUEST_OUT,
  // Memory
  input wire logic MEM_RD_OUT,
  input wire logic [31:0] MEM_ADDR_OUT,
  input wire logic MEM_VALID_IN,
  // Stream
  input wire logic TX_VALID_OUT,
  input wire logic TX_FIRST_OUT,
  input wire logic TX_LAST_OUT,
  input wire logic [2:0] TX_SPEED_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  property p_wait_one;
    (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");
  property p_wait_pulse;
    !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("bus answer long");
  property p_mem_hold;
    MEM_RD_OUT && !MEM_VALID_IN |=> MEM_RD_OUT && $stable(MEM_ADDR_OUT);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("read dropped");
  property p_mem_drop;
    MEM_RD_OUT && MEM_VALID_IN |=> !MEM_RD_OUT;
  endproperty
  a_mem_drop: assert property (p_mem_drop) else $error("read kept");
  property p_mem_align;
    MEM_RD_OUT |-> MEM_ADDR_OUT[1:0] == 2'h0;
  endproperty
  a_mem_align: assert property (p_mem_align) else $error("read unaligned");
  property p_first_valid;
    TX_FIRST_OUT |-> TX_VALID_OUT;
  endproperty
  a_first_valid: assert property (p_first_valid) else $error("stray first");
  property p_speed_hold;
    TX_VALID_OUT && !TX_FIRST_OUT |-> $stable(TX_SPEED_OUT);
  endproperty
  a_speed_hold: assert property (p_speed_hold) else $error("speed moved");
  // Next packet needs six fetches first
  property p_last_gap;
    TX_LAST_OUT |=> !TX_VALID_OUT [*4];
  endproperty
  a_last_gap: assert property (p_last_gap) else $error("packet overrun");
endmodule : iso_out_checker
bind iso_out_engine iso_out_checker #(.N_CTX(N_CTX)) u_chk (
  .SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .AVS_READ_IN(AVS_READ_IN),
  .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .MEM_RD_OUT(MEM_RD_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_VALID_IN(MEM_VALID_IN),
  .TX_VALID_OUT(TX_VALID_OUT), .TX_FIRST_OUT(TX_FIRST_OUT), .TX_LAST_OUT(TX_LAST_OUT),
  .TX_SPEED_OUT(TX_SPEED_OUT)
);
`default_nettype wire

/* sim/testbench.sv */
// Register-driven bench for the transmit engine.
// Assumes host_mem_model as memory; captures the link stream itself.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, tick = 1'b0, mism = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q, mdata, txd, maddr;
  logic wreq, mrd, mval, txv, txl, irq;
  logic [2:0] spd;
  logic [31:0] txq[$];
  int n_mismatch = 0, cmp_count = 0, n_last = 0;
  always #5 clk = ~clk;
  iso_out_engine #(.N_CTX(4)) u_dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst),
    .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat),
    .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq),
    .CYCLE_TICK_IN(tick), .CYCLE_LOST_IN(1'b0), .CYCLE_MISMATCH_IN(mism),
    .MEM_RD_OUT(mrd), .MEM_ADDR_OUT(maddr), .MEM_VALID_IN(mval), .MEM_DATA_IN(mdata),
    .TX_VALID_OUT(txv), .TX_FIRST_OUT(), .TX_LAST_OUT(txl), .TX_DATA_OUT(txd),
    .TX_SPEED_OUT(spd), .IRQ_OUT(irq));
  host_mem_model u_mem (.clk_in(clk), .rst_in(rst), .rd_in(mrd), .addr_in(maddr),
    .valid_out(mval), .data_out(mdata));
  always @(posedge clk)
  begin
    if (txv === 1'b1)
      txq.push_back(txd);
    if (txl === 1'b1)
      n_last++;
  end
  task automatic close_out;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic hang(input int n);
    if (n >= 300)
    begin
      n_mismatch++;
      close_out();
    end
  endtask : hang
  // Request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 300);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    hang(n);
  endtask : bus
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(nm, e, q & m);
  endtask : rchk
  task automatic run_cycle(input int want);
    int n;
    n = 0;
    txq.delete();
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    while (n_last < want && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    hang(n);
    repeat (2) @(posedge clk);
  endtask : run_cycle
  initial
  begin
    u_mem.mem[16:21] = '{32'h1, 32'h0, 32'h0002_45a3, 32'h0005_0000, 32'h101, 32'h0};
    u_mem.mem[32:37] = '{32'h0, 32'h0, 32'h0001_0700, 32'h0, 32'h0, 32'h0};
    u_mem.mem[64:65] = '{32'h4433_2211, 32'h8877_6655};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("mask", iso_out_pkg::OFS_TX_MASK, 32'hf, iso_out_pkg::MASK_RST);
    bus(1'b1, iso_out_pkg::OFS_TX_MASK, 32'h1);
    bus(1'b1, iso_out_pkg::OFS_GLOBAL_MASK, 32'h3);
    bus(1'b1, iso_out_pkg::OFS_CTX_SEL, 32'h0);
    bus(1'b1, iso_out_pkg::OFS_CTX_PTR, 32'h41);
    bus(1'b1, iso_out_pkg::OFS_CTX_CTRL, 32'h8000);
    rchk("active", iso_out_pkg::OFS_CTX_CTRL, 32'h400, 32'h400);
    run_cycle(1);
    check("quadlets", 32'h3, txq.size());
    check("header", 32'h0005_45a3, txq[0]);
    check("data0", 32'h2233_4455, txq[1]);
    check("data1", 32'h6600_0000, txq[2]);
    check("speed", 32'h2, {29'h0, spd});
    check("irq", 32'h1, {31'h0, irq});
    rchk("summary", iso_out_pkg::OFS_GLOBAL, 32'h1, 32'h1);
    rchk("events", iso_out_pkg::OFS_TX_EVENT, 32'hf, 32'h1);
    rchk("events", iso_out_pkg::OFS_TX_EVENT, 32'hf, 32'h0);
    check("irq", 32'h0, {31'h0, irq});
    rchk("active", iso_out_pkg::OFS_CTX_CTRL, 32'h400, 32'h0);
    // Appended block linked from both pointers; the wake follows the branch
    u_mem.mem[17] = 32'h81;
    u_mem.mem[21] = 32'h81;
    bus(1'b1, iso_out_pkg::OFS_CTX_CTRL, 32'h9000);
    repeat (40) @(posedge clk);
    rchk("active", iso_out_pkg::OFS_CTX_CTRL, 32'h400, 32'h400);
    run_cycle(2);
    check("header", 32'h0000_0700, txq[0]);
    check("speed", 32'h1, {29'h0, spd});
    bus(1'b1, iso_out_pkg::OFS_CTX_CTRL, 32'h0);
    mism <= 1'b1;
    @(posedge clk);
    mism <= 1'b0;
    rchk("mismatch", iso_out_pkg::OFS_GLOBAL, 32'h2, 32'h2);
    check("irq", 32'h1, {31'h0, irq});
    bus(1'b1, iso_out_pkg::OFS_CTX_PTR, 32'h81);
    bus(1'b1, iso_out_pkg::OFS_CTX_CTRL, 32'h8000_8000);
    rchk("active", iso_out_pkg::OFS_CTX_CTRL, 32'h400, 32'h0);
    bus(1'b1, iso_out_pkg::OFS_CTX_CTRL, 32'h8000_0000);
    bus(1'b1, iso_out_pkg::OFS_GLOBAL, 32'h2);
    check("irq", 32'h0, {31'h0, irq});
    repeat (2) @(posedge clk);
    bus(1'b1, iso_out_pkg::OFS_CTX_CTRL, 32'h8000_8000);
    rchk("active", iso_out_pkg::OFS_CTX_CTRL, 32'h400, 32'h400);
    close_out();
  end
endmodule : testbench
`default_nettype wire
